// [logic/vip_pkg.sv]
package vip_pkg;

    // =========================================================
    // register byte addresses
    // =========================================================
    localparam logic [31:0] VIP_ADDR_TABLE_BASE = 32'hffff0014;
    localparam logic [31:0] VIP_ADDR_NORMAL_VEC = 32'hffff001c;
    localparam logic [31:0] VIP_ADDR_PRIO_B = 32'hffff0024;
    localparam logic [31:0] VIP_ADDR_PRIO_C = 32'hffff0028;
    localparam logic [31:0] VIP_ADDR_NEST_CTRL = 32'hffff0030;
    localparam logic [31:0] VIP_ADDR_NEST_STAT = 32'hffff003c;
    localparam logic [31:0] VIP_ADDR_FAST_VEC = 32'hffff011c;

    // =========================================================
    // reset values
    // =========================================================
    localparam logic [31:0] VIP_RST_PRIO = 32'h00000000;
    localparam logic [1:0] VIP_RST_NEST_CTRL = 2'h0;
    localparam logic [7:0] VIP_RST_NEST_STAT = 8'h00;
    localparam logic [15:0] VIP_RST_TABLE_BASE = 16'h0000;

    // =========================================================
    // field layout
    // =========================================================
    localparam int VIP_PRIO_W = 3;
    localparam int VIP_LEVELS = 8;
    localparam int VIP_SRC_W = 5;
    localparam int VIP_BASE_W = 16;
    localparam int VIP_NEST_NORMAL_BIT = 0;
    localparam int VIP_NEST_FAST_BIT = 1;
    localparam int VIP_VEC_SRC_LSB = 2;
    localparam int VIP_VEC_BASE_LSB = 7;
    localparam int VIP_VEC_BASE_MSB = 22;

    // priority field lsb positions, second register
    localparam int VIP_F_SUPPLY_MON = 28;
    localparam int VIP_F_COMPARATOR = 24;
    localparam int VIP_F_EXT_INT0 = 20;
    localparam int VIP_F_SERIAL_PERIPH = 16;
    localparam int VIP_F_TWOWIRE_B_SLAVE = 12;
    localparam int VIP_F_TWOWIRE_B_MASTER = 8;
    localparam int VIP_F_TWOWIRE_A_SLAVE = 4;
    localparam int VIP_F_TWOWIRE_A_MASTER = 0;
    // third register
    localparam int VIP_F_PULSE_MOD = 20;
    localparam int VIP_F_LOGIC_ARRAY1 = 16;
    localparam int VIP_F_EXT_INT3 = 12;
    localparam int VIP_F_EXT_INT2 = 8;
    localparam int VIP_F_LOGIC_ARRAY0 = 4;
    localparam int VIP_F_EXT_INT1 = 0;

    // source numbers of prioritised sources
    localparam int VIP_S_TWOWIRE_A_SLAVE = 8;
    localparam int VIP_S_TWOWIRE_A_MASTER = 9;
    localparam int VIP_S_TWOWIRE_B_SLAVE = 10;
    localparam int VIP_S_TWOWIRE_B_MASTER = 11;
    localparam int VIP_S_SERIAL_PERIPH = 12;
    localparam int VIP_S_EXT_INT0 = 13;
    localparam int VIP_S_COMPARATOR = 14;
    localparam int VIP_S_SUPPLY_MON = 15;
    localparam int VIP_S_EXT_INT1 = 16;
    localparam int VIP_S_LOGIC_ARRAY0 = 17;
    localparam int VIP_S_EXT_INT2 = 18;
    localparam int VIP_S_EXT_INT3 = 19;
    localparam int VIP_S_LOGIC_ARRAY1 = 20;
    localparam int VIP_S_PULSE_MOD = 21;
    // sources below this take their level from the outside register
    localparam int VIP_S_EXT_COUNT = 8;

    // =========================================================
    // types
    // =========================================================
    typedef logic [VIP_PRIO_W-1:0] vip_prio_t;

    typedef struct packed {
        logic valid;
        logic [VIP_SRC_W-1:0] src;
        vip_prio_t prio;
    } vip_win_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } vip_apb_rsp_s;

endpackage

// [logic/vip_ctrl.sv]
`timescale 1ns/1ps
module vip_ctrl
#(
    parameter int NUM_SRC = 32
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic [NUM_SRC-1:0] normal_active,
    input wire logic [NUM_SRC-1:0] fast_active,
    input wire logic [vip_pkg::VIP_S_EXT_COUNT*vip_pkg::VIP_PRIO_W-1:0]
        low_src_priority,
    output logic normal_req,
    output logic fast_req,
    output logic [1:0] nesting_enables
);
    import vip_pkg::*;

    // refuse at elaboration: sources above the field width cannot encode
    if (NUM_SRC < VIP_S_PULSE_MOD + 1 || NUM_SRC > (1 << VIP_SRC_W))
    begin : num_src_check
        $error("vip_ctrl: NUM_SRC out of range");
    end

    // =========================================================
    // state
    // =========================================================
    logic [31:0] prio_b_r, prio_b_nxt;
    logic [31:0] prio_c_r, prio_c_nxt;
    logic [1:0] nest_ctrl_r, nest_ctrl_nxt;
    logic [7:0] nest_stat_r, nest_stat_nxt;
    logic [VIP_BASE_W-1:0] base_r, base_nxt;
    vip_win_s norm_win_r, norm_win_nxt;
    vip_win_s fast_win_r, fast_win_nxt;
    vip_apb_rsp_s rsp_r, rsp_nxt;
    logic normal_req_r, normal_req_nxt;
    logic fast_req_r, fast_req_nxt;

    vip_prio_t src_prio [NUM_SRC];
    logic wr_done, rd_done;
    logic [31:0] rd_word;
    logic rd_hit;

    // =========================================================
    // per-source levels
    // =========================================================
    always_comb
    begin
        for (int s = 0; s < NUM_SRC; s++)
            src_prio[s] = '0;
        for (int s = 0; s < VIP_S_EXT_COUNT; s++)
            src_prio[s] = low_src_priority[s*VIP_PRIO_W +: VIP_PRIO_W];
        src_prio[VIP_S_SUPPLY_MON] =
            prio_b_r[VIP_F_SUPPLY_MON +: VIP_PRIO_W];
        src_prio[VIP_S_COMPARATOR] =
            prio_b_r[VIP_F_COMPARATOR +: VIP_PRIO_W];
        src_prio[VIP_S_EXT_INT0] =
            prio_b_r[VIP_F_EXT_INT0 +: VIP_PRIO_W];
        src_prio[VIP_S_SERIAL_PERIPH] =
            prio_b_r[VIP_F_SERIAL_PERIPH +: VIP_PRIO_W];
        src_prio[VIP_S_TWOWIRE_B_SLAVE] =
            prio_b_r[VIP_F_TWOWIRE_B_SLAVE +: VIP_PRIO_W];
        src_prio[VIP_S_TWOWIRE_B_MASTER] =
            prio_b_r[VIP_F_TWOWIRE_B_MASTER +: VIP_PRIO_W];
        src_prio[VIP_S_TWOWIRE_A_SLAVE] =
            prio_b_r[VIP_F_TWOWIRE_A_SLAVE +: VIP_PRIO_W];
        src_prio[VIP_S_TWOWIRE_A_MASTER] =
            prio_b_r[VIP_F_TWOWIRE_A_MASTER +: VIP_PRIO_W];
        src_prio[VIP_S_PULSE_MOD] =
            prio_c_r[VIP_F_PULSE_MOD +: VIP_PRIO_W];
        src_prio[VIP_S_LOGIC_ARRAY1] =
            prio_c_r[VIP_F_LOGIC_ARRAY1 +: VIP_PRIO_W];
        src_prio[VIP_S_EXT_INT3] =
            prio_c_r[VIP_F_EXT_INT3 +: VIP_PRIO_W];
        src_prio[VIP_S_EXT_INT2] =
            prio_c_r[VIP_F_EXT_INT2 +: VIP_PRIO_W];
        src_prio[VIP_S_LOGIC_ARRAY0] =
            prio_c_r[VIP_F_LOGIC_ARRAY0 +: VIP_PRIO_W];
        src_prio[VIP_S_EXT_INT1] =
            prio_c_r[VIP_F_EXT_INT1 +: VIP_PRIO_W];
    end

    // =========================================================
    // arbitration
    // =========================================================
    // scan from the top down so the lowest number wins ties
    function automatic vip_win_s pick(
        input logic [NUM_SRC-1:0] act,
        input logic use_prio,
        input logic [7:0] block,
        input vip_prio_t prio [NUM_SRC]
    );
        vip_win_s w;
        logic [VIP_PRIO_W:0] floor;
        w = '0;
        floor = VIP_LEVELS[VIP_PRIO_W:0];
        for (int l = VIP_LEVELS - 1; l >= 0; l--)
        begin
            if (block[l])
                floor = l[VIP_PRIO_W:0];
        end
        for (int s = NUM_SRC - 1; s >= 0; s--)
        begin
            if (act[s] && (!use_prio
                || ({1'b0, prio[s]} < floor
                && (!w.valid || prio[s] <= w.prio))))
            begin
                w.valid = 1'b1;
                w.src = s[VIP_SRC_W-1:0];
                w.prio = use_prio ? prio[s] : '0;
            end
        end
        return w;
    endfunction

    always_comb
    begin
        norm_win_nxt = pick(normal_active,
            nest_ctrl_r[VIP_NEST_NORMAL_BIT],
            nest_ctrl_r[VIP_NEST_NORMAL_BIT] ? nest_stat_r : 8'h00,
            src_prio);
        // no fast status register here, so fast nesting never blocks
        fast_win_nxt = pick(fast_active,
            nest_ctrl_r[VIP_NEST_FAST_BIT], 8'h00, src_prio);
        fast_req_nxt = fast_win_nxt.valid;
        normal_req_nxt = norm_win_nxt.valid && !fast_win_nxt.valid;
    end

    // =========================================================
    // apb slave
    // =========================================================
    // no wait state: the word is fetched in setup, answered in the first access cycle
    assign wr_done = psel && penable && rsp_r.pready && pwrite;
    assign rd_done = psel && penable && rsp_r.pready && !pwrite;

    always_comb
    begin
        rd_word = '0;
        rd_hit = 1'b1;
        unique case (paddr)
            VIP_ADDR_TABLE_BASE:
                rd_word = {16'h0000, base_r};
            VIP_ADDR_NORMAL_VEC:
                rd_word = {9'h000, base_r, norm_win_r.src, 2'b00};
            VIP_ADDR_PRIO_B:
                rd_word = prio_b_r;
            VIP_ADDR_PRIO_C:
                rd_word = prio_c_r;
            VIP_ADDR_NEST_CTRL:
                rd_word = {30'h0, nest_ctrl_r};
            VIP_ADDR_NEST_STAT:
                rd_word = {24'h000000, nest_stat_r};
            VIP_ADDR_FAST_VEC:
                rd_word = {9'h000, base_r, fast_win_r.src, 2'b00};
            default:
                rd_hit = 1'b0;
        endcase
    end

    always_comb
    begin
        rsp_nxt.pready = psel && !penable;
        rsp_nxt.pslverr = psel && !penable && !rd_hit;
        rsp_nxt.prdata = (psel && !penable && !pwrite) ? rd_word : '0;
    end

    // =========================================================
    // register writes and side effects
    // =========================================================
    always_comb
    begin
        prio_b_nxt = prio_b_r;
        prio_c_nxt = prio_c_r;
        nest_ctrl_nxt = nest_ctrl_r;
        nest_stat_nxt = nest_stat_r;
        base_nxt = base_r;
        if (wr_done)
        begin
            unique case (paddr)
                VIP_ADDR_TABLE_BASE:
                    base_nxt = pwdata[VIP_BASE_W-1:0];
                VIP_ADDR_PRIO_B:
                    prio_b_nxt = pwdata & 32'h77777777;
                VIP_ADDR_PRIO_C:
                    prio_c_nxt = pwdata & 32'h00777777;
                VIP_ADDR_NEST_CTRL:
                    nest_ctrl_nxt = pwdata[1:0];
                VIP_ADDR_NEST_STAT:
                    nest_stat_nxt = nest_stat_r & (nest_stat_r - 8'h01);
                default:
                    ;
            endcase
        end
        // normal vector read marks the level in service when normal nesting is on
        if (rd_done && paddr == VIP_ADDR_NORMAL_VEC
            && nest_ctrl_r[VIP_NEST_NORMAL_BIT] && norm_win_r.valid)
            nest_stat_nxt[norm_win_r.prio] = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prio_b_r <= VIP_RST_PRIO;
            prio_c_r <= VIP_RST_PRIO;
            nest_ctrl_r <= VIP_RST_NEST_CTRL;
            nest_stat_r <= VIP_RST_NEST_STAT;
            base_r <= VIP_RST_TABLE_BASE;
            norm_win_r <= '0;
            fast_win_r <= '0;
            rsp_r <= '0;
            normal_req_r <= 1'b0;
            fast_req_r <= 1'b0;
        end
        else
        begin
            prio_b_r <= prio_b_nxt;
            prio_c_r <= prio_c_nxt;
            nest_ctrl_r <= nest_ctrl_nxt;
            nest_stat_r <= nest_stat_nxt;
            base_r <= base_nxt;
            norm_win_r <= norm_win_nxt;
            fast_win_r <= fast_win_nxt;
            rsp_r <= rsp_nxt;
            normal_req_r <= normal_req_nxt;
            fast_req_r <= fast_req_nxt;
        end
    end

    assign pready = rsp_r.pready;
    assign pslverr = rsp_r.pslverr;
    assign prdata = rsp_r.prdata;
    assign normal_req = normal_req_r;
    assign fast_req = fast_req_r;
    assign nesting_enables = nest_ctrl_r;

endmodule

// [tb/vip_ctrl_asserts.sv]
`timescale 1ns/1ps
module vip_ctrl_asserts
import vip_pkg::*;
#(
    parameter int NUM_SRC = 32
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic [NUM_SRC-1:0] normal_active,
    input wire logic [NUM_SRC-1:0] fast_active,
    input wire logic normal_req,
    input wire logic fast_req,
    input wire logic [1:0] nesting_enables
);
    logic setup;
    logic acc;
    logic mapped;
    assign setup = psel && !penable;
    assign acc = psel && penable && pready;
    assign mapped = paddr inside {VIP_ADDR_TABLE_BASE, VIP_ADDR_NORMAL_VEC,
        VIP_ADDR_PRIO_B, VIP_ADDR_PRIO_C, VIP_ADDR_NEST_CTRL,
        VIP_ADDR_NEST_STAT, VIP_ADDR_FAST_VEC};
    default clocking dcb @(posedge clk); endclocking
    default disable iff (rst);
    // ====
    // bus timing and registers
    // ====
    ready_after_setup_a: assert property (setup |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    unmapped_err_a: assert property (setup && !mapped |=> pslverr
        && prdata == 32'h0) else $error("unmapped access not refused");
    // the enables output is the control flop itself, so no lag
    ctrl_write_a: assert property (
        acc && pwrite && paddr == VIP_ADDR_NEST_CTRL
        |=> nesting_enables == $past(pwdata[1:0]))
        else $error("nesting enables not written");
    vec_zero_bits_a: assert property (
        setup && !pwrite && paddr == VIP_ADDR_FAST_VEC
        |=> prdata[31:23] == 9'h0 && prdata[1:0] == 2'h0)
        else $error("fast vector zero bits set");
    // ====
    // request outputs
    // ====
    fast_wins_a: assert property (fast_req |-> !normal_req)
        else $error("normal request beside fast");
    fast_follow_a: assert property (|fast_active |=> fast_req)
        else $error("fast request missing");
    plain_normal_a: assert property (
        !nesting_enables[0] && |normal_active && fast_active == '0
        |=> normal_req) else $error("normal request missing");
    cover property (acc && !pwrite && paddr == VIP_ADDR_FAST_VEC);
    cover property (fast_req && |normal_active);
    cover property (acc && pwrite && paddr == VIP_ADDR_NEST_STAT);
endmodule

bind vip_ctrl vip_ctrl_asserts #(.NUM_SRC(NUM_SRC)) vip_ctrl_asserts_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .normal_active(normal_active),
    .fast_active(fast_active), .normal_req(normal_req),
    .fast_req(fast_req), .nesting_enables(nesting_enables)
);

// [tb/vip_core_model.sv]
`timescale 1ns/1ps
module vip_core_model
#(
    parameter int NUM_SRC = 32
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [NUM_SRC-1:0] want_normal,
    input wire logic [NUM_SRC-1:0] want_fast,
    input wire logic fast_req,
    output logic [NUM_SRC-1:0] normal_active,
    output logic [NUM_SRC-1:0] fast_active,
    output logic in_fast
);
    // ====
    // source lines and service state
    // ====
    // lines move just after the edge, like a registered peripheral flag
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            normal_active <= '0;
            fast_active <= '0;
            in_fast <= 1'b0;
        end
        else
        begin
            normal_active <= want_normal;
            fast_active <= want_fast;
            in_fast <= fast_req;
        end
    end
endmodule

// [tb/vip_ctrl_tb_top.sv]
`timescale 1ns/1ps
module vip_ctrl_tb_top;
    import vip_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [23:0] low_src_priority = 24'h0;
    logic [31:0] want_normal = 32'h0;
    logic [31:0] want_fast = 32'h0;
    logic pready, pslverr, normal_req, fast_req, in_fast, err;
    logic [31:0] prdata, normal_active, fast_active, rd;
    logic [1:0] nesting_enables;
    int failures = 0;
    int samples_checked = 0;
    always #2.5 clk = ~clk;
    vip_ctrl vip_ctrl_inst (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .normal_active(normal_active), .fast_active(fast_active),
        .low_src_priority(low_src_priority), .normal_req(normal_req),
        .fast_req(fast_req), .nesting_enables(nesting_enables)
    );
    vip_core_model vip_core_model_inst (
        .clk(clk), .rst(rst), .want_normal(want_normal),
        .want_fast(want_fast), .fast_req(fast_req),
        .normal_active(normal_active), .fast_active(fast_active),
        .in_fast(in_fast)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("failures %0d checks %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ====
    // bus master and helpers
    // ====
    task automatic apb(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // only the watchdog ends a wait that never sees ready
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // request path: model flop, design flop, then the model's service flag
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask
    function automatic logic [31:0] vec(input logic [4:0] s);
        return {9'h0, 16'hffff, s, 2'h0};
    endfunction
    // ====
    // scenarios
    // ====
    task automatic t_regs();
        rdchk(VIP_ADDR_PRIO_B, 32'h0);
        rdchk(VIP_ADDR_PRIO_C, 32'h0);
        rdchk(VIP_ADDR_NEST_CTRL, 32'h0);
        rdchk(VIP_ADDR_NEST_STAT, 32'h0);
        rdchk(VIP_ADDR_TABLE_BASE, 32'h0);
        apb(1'b1, VIP_ADDR_PRIO_B, 32'hffffffff);
        rdchk(VIP_ADDR_PRIO_B, 32'h77777777);
        apb(1'b1, VIP_ADDR_PRIO_C, 32'hffffffff);
        rdchk(VIP_ADDR_PRIO_C, 32'h00777777);
        apb(1'b1, VIP_ADDR_TABLE_BASE, 32'hffffffff);
        rdchk(VIP_ADDR_TABLE_BASE, 32'h0000ffff);
        apb(1'b0, 32'hffff0040, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask
    task automatic t_fast();
        apb(1'b1, VIP_ADDR_PRIO_B, 32'h0);
        low_src_priority <= 24'h005000;
        apb(1'b1, VIP_ADDR_NEST_CTRL, 32'h2);
        want_fast <= 32'h210;
        want_normal <= 32'h400000;
        settle();
        chk({30'h0, normal_req, fast_req}, 32'h1);
        chk({31'h0, in_fast}, 32'h1);
        rdchk(VIP_ADDR_FAST_VEC, vec(5'd9));
        low_src_priority <= 24'h0;
        settle();
        rdchk(VIP_ADDR_FAST_VEC, vec(5'd4));
        want_fast <= 32'h0;
        settle();
        chk({30'h0, normal_req, fast_req}, 32'h2);
    endtask
    task automatic t_nest();
        apb(1'b1, VIP_ADDR_PRIO_B, 32'h00300000);
        apb(1'b1, VIP_ADDR_PRIO_C, 32'h00060000);
        apb(1'b1, VIP_ADDR_NEST_CTRL, 32'h1);
        want_normal <= 32'h102000;
        settle();
        rdchk(VIP_ADDR_NORMAL_VEC, vec(5'd13));
        rdchk(VIP_ADDR_NEST_STAT, 32'h08);
        chk({31'h0, normal_req}, 32'h0);
        want_normal <= 32'h502000;
        settle();
        chk({31'h0, normal_req}, 32'h1);
        rdchk(VIP_ADDR_NORMAL_VEC, vec(5'd22));
        rdchk(VIP_ADDR_NEST_STAT, 32'h09);
        apb(1'b1, VIP_ADDR_NEST_STAT, 32'hff);
        rdchk(VIP_ADDR_NEST_STAT, 32'h08);
        apb(1'b1, VIP_ADDR_NEST_STAT, 32'hff);
        rdchk(VIP_ADDR_NEST_STAT, 32'h00);
    endtask
    task automatic t_plain();
        apb(1'b1, VIP_ADDR_NEST_CTRL, 32'h0);
        apb(1'b1, VIP_ADDR_PRIO_B, 32'h00600000);
        apb(1'b1, VIP_ADDR_PRIO_C, 32'h0);
        want_normal <= 32'h102000;
        settle();
        rdchk(VIP_ADDR_NORMAL_VEC, vec(5'd13));
        rdchk(VIP_ADDR_NEST_STAT, 32'h0);
        chk({30'h0, nesting_enables}, 32'h0);
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_fast();
        t_nest();
        t_plain();
        finish_test();
    end
    initial
    begin
        repeat (2000) @(posedge clk);
        failures++;
        finish_test();
    end
endmodule
